// ### hdl/resource_session_pkg.sv
// Purpose: Shared constants and types for the resource session handler
// Assumes: Messages are carried as decoded codes, not character streams
// Notes:   Cause strings are four ASCII characters packed into 32 bits
package resource_session_pkg;
    localparam int unsigned COUNT_W        = 10;
    localparam logic [9:0]  COUNT_MAX      = 10'h3e7;
    localparam logic [9:0]  COUNT_ZERO     = 10'h000;
    localparam logic [9:0]  COUNT_ONE      = 10'h001;
    localparam int unsigned CAUSE_W        = 32;
    localparam logic [31:0] CAUSE_SESSION_MESSAGE_COUNT     = 32'h4e4d5347;
    localparam logic [31:0] CAUSE_NONE     = 32'h00000000;

    // Message kinds sent downstream by this device
    typedef enum logic [2:0]
    {
        TX_NONE   = 3'h0,
        TX_OPEN   = 3'h1,
        TX_BODY   = 3'h2,
        TX_CLOSE  = 3'h3
    } tx_kind_e;

    // Body message classes
    typedef enum logic [1:0]
    {
        BODY_MSC   = 2'h0,
        BODY_FIC   = 2'h1,
        BODY_OTHER = 2'h2
    } body_class_e;

    // Session states, Gray coded along idle, open, body, close
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_OPEN  = 2'b01,
        ST_BODY  = 2'b11,
        ST_CLOSE = 2'b10
    } sess_state_e;
endpackage

// ### hdl/session_track_if.sv
// Purpose: Carries session progress between the handler and its counter
// Assumes: Single clock domain
// Notes:   Counter owns the remaining-message count
`timescale 1ns/1ps
interface session_track_if;
    logic                                       load;
    logic                                       step;
    logic [resource_session_pkg::COUNT_W-1:0]   loadValue;
    logic [resource_session_pkg::COUNT_W-1:0]   remaining;
    logic                                       done;

    modport handler (output load, output step, output loadValue,
                     input remaining, input done);
    modport counter (input load, input step, input loadValue,
                     output remaining, output done);
endinterface

// ### hdl/session_counter.sv
// Purpose: Counts body messages still owed in the open session
// Assumes: Load and step never coincide
// Notes:   Saturates at zero so an extra step cannot wrap
`timescale 1ns/1ps
module session_counter
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Tracking link
    session_track_if.counter trk
);
    logic [resource_session_pkg::COUNT_W-1:0] remaining_r;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            remaining_r <= resource_session_pkg::COUNT_ZERO;
        else if (trk.load)
            remaining_r <= trk.loadValue;
        else if (trk.step && remaining_r != resource_session_pkg::COUNT_ZERO)
            remaining_r <= remaining_r - resource_session_pkg::COUNT_ONE;
    end

    assign trk.remaining = remaining_r;
    assign trk.done      = (remaining_r == resource_session_pkg::COUNT_ZERO);
endmodule // session_counter

// ### hdl/resource_session_handler.sv
// Purpose: Downstream end of the resource data exchange session
// Assumes: Upstream requests and aborts arrive as decoded one-cycle strobes
// Notes:   The allocation source is sampled when each body message leaves
`timescale 1ns/1ps
// Operation
// R1 - Upstream asks for its allocation by sending the info request.
// R2 - An info request is answered by opening a session.
// R3 - Allocation messages leave only inside an open session.
// R4 - Sent allocation values are those in force at send time.
// R5 - A recipient aborting a session states the reason.
// R6 - This device never sends the info request.
// R7 - Only this device sends the session opening message.
// R8 - Sending the opening message starts a new session.
// R9 - Opening message carries message count from 0 to 999.
// R10 - Exactly the announced number of messages follow, then the close.
// R11 - Close is sent only after all announced messages.
// R12 - Only this device sends the close, ending the session.
// R13 - Only upstream sends the abort, which ends the session.
// R14 - Abort carries four-character cause; SESSION_MESSAGE_COUNT means count mismatch.
// R15 - At most one MSC and one FIC capacity message per session.
// R16 - Capacity, limit and identifier messages only during an open session.
// R17 - Upstream counts body messages and reports SESSION_MESSAGE_COUNT on mismatch.
// R18 - Session state is idle or open; stray inputs ignored; idle on close or abort. The code queues a mid-session info request instead.
module resource_session_handler
#(
    parameter int unsigned COUNT_W = resource_session_pkg::COUNT_W
)
(
    // Clock and reset
    input  wire logic                                      sys_clk,
    input  wire logic                                      rst_n,
    // Upstream requests
    input  wire logic                                      infoReq,
    input  wire logic                                      abortReq,
    input  wire logic [resource_session_pkg::CAUSE_W-1:0]  abortCause,
    // Allocation source
    input  wire logic [COUNT_W-1:0]                        sessionMessageCount,
    input  wire logic                                      bodyValid,
    input  wire resource_session_pkg::body_class_e         bodyClass,
    input  wire logic [31:0]                               bodyData,
    // Outgoing message
    output logic                                           txValid,
    output resource_session_pkg::tx_kind_e                 txKind,
    output logic [COUNT_W-1:0]                             txCount,
    output resource_session_pkg::body_class_e              txClass,
    output logic [31:0]                                    txData,
    // Status
    output logic                                           bodyTaken,
    output logic                                           bodyRefused,
    output logic                                           sessionOpen,
    output logic                                           abortSeen,
    output logic [resource_session_pkg::CAUSE_W-1:0]       abortCauseOut,
    output logic                                           nmsgAbort
);
    // Counter and interface are sized by the package, so widths must agree
    if (COUNT_W != resource_session_pkg::COUNT_W)
    begin : g_width_check
        $error("COUNT_W must match the package count width");
    end

    resource_session_pkg::sess_state_e state_r;
    resource_session_pkg::sess_state_e state_nxt;
    session_track_if                   trk ();
    logic                              mscSent_r;
    logic                              ficSent_r;
    logic                              pendingReq_r;
    logic [COUNT_W-1:0]                clampedCount;
    logic                              bodyOk;
    logic                              classDup;

    session_counter u_counter
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .trk     (trk)
    );

    // Counts above 999 cannot be announced, so clamp
    assign clampedCount = (sessionMessageCount > resource_session_pkg::COUNT_MAX)
                        ? resource_session_pkg::COUNT_MAX : sessionMessageCount; // R9

    assign classDup = (bodyClass == resource_session_pkg::BODY_MSC && mscSent_r)
                   || (bodyClass == resource_session_pkg::BODY_FIC && ficSent_r); // R15
    // Body leaves only while open and still owed
    assign bodyOk   = (state_r == resource_session_pkg::ST_BODY) && bodyValid
                   && !trk.done && !classDup && !abortReq; // R3 R16 R10

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            resource_session_pkg::ST_IDLE:
                if (infoReq || pendingReq_r)
                    state_nxt = resource_session_pkg::ST_OPEN; // R2
            resource_session_pkg::ST_OPEN:
                if (abortReq)
                    state_nxt = resource_session_pkg::ST_IDLE; // R13
                else
                    state_nxt = resource_session_pkg::ST_BODY; // R8
            resource_session_pkg::ST_BODY:
                if (abortReq)
                    state_nxt = resource_session_pkg::ST_IDLE; // R13
                else if (trk.done)
                    state_nxt = resource_session_pkg::ST_CLOSE; // R11
            resource_session_pkg::ST_CLOSE:
                state_nxt = resource_session_pkg::ST_IDLE; // R12
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= resource_session_pkg::ST_IDLE;
        else
            state_r <= state_nxt; // R18
    end

    // Request seen mid-session is served once the session ends
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pendingReq_r <= 1'b0;
        else if (infoReq && state_r != resource_session_pkg::ST_IDLE)
            pendingReq_r <= 1'b1;
        else if (state_r == resource_session_pkg::ST_IDLE)
            pendingReq_r <= 1'b0;
    end

    assign trk.load      = (state_r == resource_session_pkg::ST_OPEN);
    assign trk.loadValue = clampedCount;
    assign trk.step      = bodyOk;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mscSent_r <= 1'b0;
            ficSent_r <= 1'b0;
        end
        else if (state_r == resource_session_pkg::ST_OPEN)
        begin
            mscSent_r <= 1'b0;
            ficSent_r <= 1'b0;
        end
        else if (bodyOk)
        begin
            if (bodyClass == resource_session_pkg::BODY_MSC)
                mscSent_r <= 1'b1; // R15
            if (bodyClass == resource_session_pkg::BODY_FIC)
                ficSent_r <= 1'b1; // R15
        end
    end

    // Outgoing message; never an info request or abort from here
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txValid <= 1'b0;
            txKind  <= resource_session_pkg::TX_NONE;
            txCount <= resource_session_pkg::COUNT_ZERO;
            txClass <= resource_session_pkg::BODY_OTHER;
            txData  <= 32'h00000000;
        end
        else
        begin
            txValid <= 1'b0;
            txKind  <= resource_session_pkg::TX_NONE; // R6 R7
            if (state_r == resource_session_pkg::ST_OPEN)
            begin
                txValid <= 1'b1;
                txKind  <= resource_session_pkg::TX_OPEN; // R8
                txCount <= clampedCount; // R9
            end
            else if (bodyOk)
            begin
                txValid <= 1'b1;
                txKind  <= resource_session_pkg::TX_BODY;
                txClass <= bodyClass;
                txData  <= bodyData; // R4
            end
            // An aborted session gets no close
            else if (state_r == resource_session_pkg::ST_CLOSE && !abortReq)
            begin
                txValid <= 1'b1;
                txKind  <= resource_session_pkg::TX_CLOSE; // R12
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bodyTaken   <= 1'b0;
            bodyRefused <= 1'b0;
            sessionOpen <= 1'b0;
        end
        else
        begin
            bodyTaken   <= bodyOk;
            bodyRefused <= bodyValid && !bodyOk; // R16
            sessionOpen <= (state_nxt != resource_session_pkg::ST_IDLE);
        end
    end

    // Abort only counts while a session is open
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            abortSeen     <= 1'b0;
            abortCauseOut <= resource_session_pkg::CAUSE_NONE;
            nmsgAbort     <= 1'b0;
        end
        else
        begin
            abortSeen <= 1'b0;
            nmsgAbort <= 1'b0;
            if (abortReq && state_r != resource_session_pkg::ST_IDLE)
            begin
                abortSeen     <= 1'b1; // R5 R13
                abortCauseOut <= abortCause; // R14
                nmsgAbort     <= (abortCause == resource_session_pkg::CAUSE_SESSION_MESSAGE_COUNT); // R17
            end
        end
    end
endmodule // resource_session_handler

// ### sim/resource_session_props.sv
// Purpose: Port checks of the resource session handler
// Assumes: One clock, rst_n asynchronous active low
// Notes:   owed_r tracks messages still owed in the session
`timescale 1ns/1ps
module resource_session_props
#(
    parameter int unsigned COUNT_W = 10
)
(
    // Clock, reset, requests
    input wire logic                              sys_clk,
    input wire logic                              rst_n,
    input wire logic                              infoReq,
    input wire logic                              abortReq,
    input wire logic [31:0]                       abortCause,
    input wire logic                              bodyValid,
    // Messages and status
    input wire logic                              txValid,
    input wire resource_session_pkg::tx_kind_e    txKind,
    input wire logic [COUNT_W-1:0]                txCount,
    input wire resource_session_pkg::body_class_e txClass,
    input wire logic                              bodyTaken,
    input wire logic                              bodyRefused,
    input wire logic                              sessionOpen,
    input wire logic                              abortSeen,
    input wire logic [31:0]                       abortCauseOut,
    input wire logic                              nmsgAbort
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [COUNT_W-1:0] owed_r;
    logic [1:0]         seen_r;
    wire txOpen  = txValid && txKind == resource_session_pkg::TX_OPEN;
    wire txBody  = txValid && txKind == resource_session_pkg::TX_BODY;
    wire txClose = txValid && txKind == resource_session_pkg::TX_CLOSE;
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
            owed_r <= '0;
        else if (txOpen)
            owed_r <= txCount;
        else if (txBody)
            owed_r <= owed_r - 1'b1;
    // Abort leaves stale bits; the next open clears them
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
            seen_r <= '0;
        else if (txOpen)
            seen_r <= '0;
        else if (txBody && txClass != resource_session_pkg::BODY_OTHER)
            seen_r[txClass[0]] <= 1'b1;
    a_open_answers_info: assert property (infoReq && !sessionOpen |-> ##[1:3] txOpen)
        else $error("no open after info request");
    a_open_count_range: assert property (txOpen |-> txCount <= 10'h3e7)
        else $error("announced count above 999");
    a_body_owed_only: assert property (txBody |-> sessionOpen && owed_r != '0)
        else $error("body sent outside owed session");
    a_close_after_all: assert property (txClose |-> owed_r == '0)
        else $error("close before all bodies");
    a_one_per_channel: assert property (txBody && txClass != resource_session_pkg::BODY_OTHER
        |-> !seen_r[txClass[0]])
        else $error("second capacity message of a channel");
    a_taken_is_sent: assert property (bodyTaken |-> txBody)
        else $error("taken body not sent");
    a_abort_reports_cause: assert property (abortReq && sessionOpen
        |=> abortSeen && abortCauseOut == $past(abortCause))
        else $error("abort cause not reported");
    a_abort_ends_session: assert property (abortReq && sessionOpen
        |=> !sessionOpen ##1 !txClose [*2])
        else $error("session survives abort");
    a_session_message_count_flag_match: assert property (nmsgAbort
        == (abortSeen && abortCauseOut == resource_session_pkg::CAUSE_SESSION_MESSAGE_COUNT))
        else $error("count mismatch flag wrong");
    a_idle_body_refused: assert property (bodyValid && !sessionOpen
        |=> bodyRefused && !bodyTaken)
        else $error("idle body not refused");
    c_empty_session: cover property (txOpen ##2 txClose);
    c_queued_request: cover property (infoReq && sessionOpen);
    c_session_message_count_abort: cover property (nmsgAbort);
    c_refused_open: cover property (bodyRefused && sessionOpen);
endmodule // resource_session_props
bind resource_session_handler resource_session_props #(.COUNT_W(COUNT_W)) resource_session_props_i
    (.sys_clk, .rst_n, .infoReq, .abortReq, .abortCause, .bodyValid, .txValid, .txKind, .txCount,
     .txClass, .bodyTaken, .bodyRefused, .sessionOpen, .abortSeen, .abortCauseOut, .nmsgAbort);

// ### sim/upstream_model.sv
// Purpose: Upstream entity: info requests, aborts, body count
// Assumes: Requests change on the falling edge
// Notes:   Idle cause lines show the inverse of the last cause
`timescale 1ns/1ps
module upstream_model
(
    // Clock
    input  wire logic                           sys_clk,
    // Requests
    output logic                                infoReq,
    output logic                                abortReq,
    output logic [31:0]                         abortCause,
    // Observed messages
    input  wire logic                           txValid,
    input  wire resource_session_pkg::tx_kind_e txKind
);
    int bodies = 0;
    initial {infoReq, abortReq, abortCause} = '0;
    always @(posedge sys_clk)
        if (txValid && txKind == resource_session_pkg::TX_OPEN)
            bodies = 0;
        else if (txValid && txKind == resource_session_pkg::TX_BODY)
            bodies = bodies + 1;
    task automatic ask();
        @(negedge sys_clk) infoReq = 1'b1;
        @(negedge sys_clk) infoReq = 1'b0;
    endtask
    task automatic abort(input logic [31:0] cause);
        @(negedge sys_clk) {abortReq, abortCause} = {1'b1, cause};
        @(negedge sys_clk) {abortReq, abortCause} = {1'b0, ~cause};
    endtask
endmodule // upstream_model

// ### sim/resource_session_handler_tb_top.sv
// Purpose: Self-checking bench of the resource session handler
// Assumes: Inputs change on the falling edge
// Notes:   Upstream side played by upstream_model
`timescale 1ns/1ps
module resource_session_handler_tb_top;
    logic                              sys_clk = 1'b0;
    logic                              rst_n = 1'b0;
    logic                              infoReq, abortReq, bodyValid = 1'b0;
    logic [31:0]                       abortCause, bodyData = '0, txData, abortCauseOut;
    logic [9:0]                        sessionMessageCount = '0, txCount;
    resource_session_pkg::body_class_e bodyClass = resource_session_pkg::BODY_OTHER, txClass;
    resource_session_pkg::tx_kind_e    txKind;
    logic                              txValid, bodyTaken, bodyRefused;
    logic                              sessionOpen, abortSeen, nmsgAbort;
    int nMismatch = 0, nCompared = 0, opens, bodies, closes, refused, aborts, nmsgs;
    always #50 sys_clk = ~sys_clk;
    resource_session_handler resource_session_handler_i (.sys_clk, .rst_n, .infoReq, .abortReq,
        .abortCause, .sessionMessageCount, .bodyValid, .bodyClass, .bodyData, .txValid, .txKind,
        .txCount, .txClass, .txData, .bodyTaken, .bodyRefused, .sessionOpen, .abortSeen,
        .abortCauseOut, .nmsgAbort);
    upstream_model upstream_model_i (.sys_clk, .infoReq, .abortReq, .abortCause, .txValid,
        .txKind);
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        nCompared++;
        if (seen !== want)
        begin
            nMismatch++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // Tallies messages; bodyData moves every cycle
    task automatic watch(input int cyc);
        {opens, bodies, closes, refused, aborts, nmsgs} = '0;
        repeat (cyc)
        begin
            @(negedge sys_clk);
            if (txValid && txKind == resource_session_pkg::TX_BODY)
            begin
                check(txData, bodyData);
                check(txClass, bodyClass);
                check(bodyTaken, 1'b1);
            end
            opens += txValid && txKind == resource_session_pkg::TX_OPEN;
            bodies += txValid && txKind == resource_session_pkg::TX_BODY;
            closes += txValid && txKind == resource_session_pkg::TX_CLOSE;
            refused += bodyRefused;
            aborts += abortSeen;
            nmsgs += nmsgAbort;
            bodyData = bodyData + 32'h1;
        end
    endtask
    task automatic sc_idle();
        bodyValid = 1'b1;
        fork
            upstream_model_i.abort(resource_session_pkg::CAUSE_SESSION_MESSAGE_COUNT);
            watch(4);
        join
        bodyValid = 1'b0;
        check(refused, 4);
        check(opens + bodies, 0);
        check(aborts, 0);
    endtask
    task automatic sc_full(input logic [9:0] n, input int want);
        sessionMessageCount = n;
        bodyValid = 1'b1;
        upstream_model_i.ask();
        watch(want + 8);
        bodyValid = 1'b0;
        check(opens, 1);
        check(txCount, want);
        check(bodies, want);
        check(upstream_model_i.bodies, want);
        check(closes, 1);
        check(sessionOpen, 0);
    endtask
    // A request during a session is served once it closes
    task automatic sc_queue();
        sessionMessageCount = 10'h002;
        bodyClass = resource_session_pkg::BODY_OTHER;
        bodyValid = 1'b1;
        fork
            begin
                upstream_model_i.ask();
                upstream_model_i.ask();
            end
            watch(16);
        join
        bodyValid = 1'b0;
        check(opens, 2);
        check(bodies, 4);
        check(closes, 2);
        check(upstream_model_i.bodies, 2);
    endtask
    // Reset in mid-session drops the session and sends nothing after
    task automatic sc_reset();
        sessionMessageCount = 10'h005;
        bodyClass = resource_session_pkg::BODY_OTHER;
        bodyValid = 1'b1;
        upstream_model_i.ask();
        watch(3);
        check(sessionOpen, 1);
        rst_n = 1'b0;
        @(negedge sys_clk);
        check({txValid, bodyTaken, sessionOpen, abortSeen}, 4'h0);
        rst_n = 1'b1;
        watch(4);
        bodyValid = 1'b0;
        check(opens + bodies + closes, 0);
        check(refused, 4);
    endtask
    task automatic sc_abort(input logic [31:0] cause,
                            input resource_session_pkg::body_class_e cls);
        sessionMessageCount = 10'h014;
        bodyClass = cls;
        bodyValid = 1'b1;
        upstream_model_i.ask();
        watch(8);
        check(bodies, 1);
        check(refused > 0, 1);
        fork
            upstream_model_i.abort(cause);
            watch(6);
        join
        bodyValid = 1'b0;
        check(aborts, 1);
        check(abortCauseOut, cause);
        check(nmsgs, cause === resource_session_pkg::CAUSE_SESSION_MESSAGE_COUNT);
        check(closes, 0);
        check(sessionOpen, 0);
    endtask
    task automatic give_verdict();
        $display("compared=%0d mismatched=%0d", nCompared, nMismatch);
        if (nMismatch == 0 && nCompared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        sc_idle();
        sc_full(10'h000, 0);
        sc_full(10'h003, 3);
        sc_full(10'h3ff, 999);
        sc_queue();
        sc_abort(resource_session_pkg::CAUSE_SESSION_MESSAGE_COUNT, resource_session_pkg::BODY_MSC);
        sc_abort(32'h41424344, resource_session_pkg::BODY_FIC);
        sc_reset();
        give_verdict();
    end
    // About 1100 cycles expected; allow several times that
    initial
    begin
        #500_000;
        nMismatch++;
        give_verdict();
    end
endmodule // resource_session_handler_tb_top
